// ### verilog/clc_pkg.sv
// Package with register map, field layout and mode codes of the logic cell.
// Behaviour
// - Mode bits 2:0 of low control: 000 AND-OR, 001 OR-XOR, 010 AND.
// - Mode 100 makes a one-input D flip-flop with set and reset.
// - Mode 101 makes a two-input D flip-flop with reset.
// - Mode 110 makes a JK flip-flop with reset.
// - Mode 111 makes a one-input transparent latch with set and reset.
// - High control bit 0 set inverts channel 1, clear passes it.
// - High control bit 1 set inverts channel 2, clear passes it.
// - High control bit 2 set inverts channel 3, clear passes it.
// - High control bit 3 set inverts channel 4, clear passes it.
// - High control bits 15 to 4 read zero and ignore writes.
package clc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_LOW_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_HIGH_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [DATA_W-1:0] CTRL_LOW_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_HIGH_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_HIGH_MASK = 16'h000F;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned INV_W = 4;
  localparam int unsigned INV_LSB = 0;
  localparam int unsigned CH1 = 0;
  localparam int unsigned CH2 = 1;
  localparam int unsigned CH3 = 2;
  localparam int unsigned CH4 = 3;
  localparam int unsigned STATE_BIT = 0;

  typedef enum logic [2:0] {
    CLC_AND_OR = 3'b000,
    CLC_OR_XOR = 3'b001,
    CLC_AND4 = 3'b010,
    CLC_SR_LATCH = 3'b011,
    CLC_DFF_SR = 3'b100,
    CLC_DFF2_R = 3'b101,
    CLC_JKFF_R = 3'b110,
    CLC_DLATCH_SR = 3'b111
  } clc_mode_t;
endpackage : clc_pkg

// ### verilog/clc_core.sv
// Configurable logic cell with polarity control and register port.
`timescale 1ns/1ps
module clc_core
  import clc_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [INV_W-1:0] gate_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic cell_out
);
  // Stored state of the block: control words, read data, cell state and edge history.
  logic [DATA_W-1:0] ctrl_low_q;
  logic [DATA_W-1:0] ctrl_low_d;
  logic [DATA_W-1:0] ctrl_high_q;
  logic [DATA_W-1:0] ctrl_high_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic state_q;
  logic state_d;
  logic clk_prev_q;
  logic clk_prev_d;
  logic out_q;
  logic out_d;

  // Decoded strobes, adjusted channels and the role that each channel plays.
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;
  logic rd_status;
  logic [INV_W-1:0] g;
  clc_mode_t mode;
  logic comb_val;
  logic rise;
  logic latch_en;
  logic ff_data;
  logic ff_data_pair;
  logic ff_set;
  logic ff_rst;
  logic jk_j;
  logic jk_k;
  logic sr_set;
  logic sr_rst;

  // Channel roles per mode; reset always wins over set, and all updates are
  // taken on the rising edge of clock_in, so the latches are sampled versions.
  //   AND-OR       : (ch1 and ch2) or (ch3 and ch4).
  //   OR-XOR       : (ch1 or ch2) xor (ch3 or ch4).
  //   AND          : ch1 and ch2 and ch3 and ch4.
  //   SR latch     : set is ch1 or ch2, reset is ch3 or ch4.
  //   D flip-flop  : clock is ch1 rising, data ch2, set ch3, reset ch4.
  //   Two-input D  : clock is ch1 rising, data ch2 and ch3, reset ch4.
  //   JK flip-flop : clock is ch1 rising, J ch2, K ch3, reset ch4.
  //   D latch      : enable is ch1 high, data ch2, set ch3, reset ch4.
  // A channel that a mode does not list is ignored by that mode.
  // A rising edge is ch1 high now after being low at the previous clock edge.

  // Matches one register strobe against one register address.
  function automatic logic reg_hit(
    input logic strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    return strobe && (addr == target);
  endfunction : reg_hit

  // Applies one polarity bit to one gate channel.
  function automatic logic apply_pol(
    input logic raw,
    input logic invert
  );
    return raw ^ invert;
  endfunction : apply_pol

  // Tells the combinational modes apart from the stored ones.
  function automatic logic is_comb_mode(
    input clc_mode_t m
  );
    logic result;
    result = 1'b0;
    case (m)
      CLC_AND_OR: begin
        result = 1'b1;
      end
      CLC_OR_XOR: begin
        result = 1'b1;
      end
      CLC_AND4: begin
        result = 1'b1;
      end
      default: begin
        result = 1'b0;
      end
    endcase
    return result;
  endfunction : is_comb_mode

  // Evaluates the three gate functions; stored modes give zero here.
  function automatic logic comb_eval(
    input clc_mode_t m,
    input logic [INV_W-1:0] gv
  );
    logic result;
    result = 1'b0;
    case (m)
      CLC_AND_OR: begin
        result = (gv[CH1] & gv[CH2]) | (gv[CH3] & gv[CH4]);
      end
      CLC_OR_XOR: begin
        result = (gv[CH1] | gv[CH2]) ^ (gv[CH3] | gv[CH4]);
      end
      CLC_AND4: begin
        result = &gv;
      end
      default: begin
        result = 1'b0;
      end
    endcase
    return result;
  endfunction : comb_eval

  // Next JK state: hold, set, clear or toggle.
  function automatic logic jk_next(
    input logic j,
    input logic k,
    input logic q
  );
    logic result;
    result = q;
    if (j && k) begin
      result = ~q;
    end else if (j) begin
      result = 1'b1;
    end else if (k) begin
      result = 1'b0;
    end
    return result;
  endfunction : jk_next

  // Address decoding of the two strobes.
  assign wr_low = reg_hit(wr_in, addr_in, CTRL_LOW_ADDR);
  assign wr_high = reg_hit(wr_in, addr_in, CTRL_HIGH_ADDR);
  assign rd_low = reg_hit(rd_in, addr_in, CTRL_LOW_ADDR);
  assign rd_high = reg_hit(rd_in, addr_in, CTRL_HIGH_ADDR);
  assign rd_status = reg_hit(rd_in, addr_in, STATUS_ADDR);

  // Control words; only the four polarity bits of the high word can be stored.
  always_comb begin
    ctrl_low_d = ctrl_low_q;
    ctrl_high_d = ctrl_high_q;
    if (wr_low) begin
      ctrl_low_d = wdata_in;
    end else if (wr_high) begin
      ctrl_high_d = wdata_in & CTRL_HIGH_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_low_q <= CTRL_LOW_RESET;
      ctrl_high_q <= CTRL_HIGH_RESET;
    end else begin
      ctrl_low_q <= ctrl_low_d;
      ctrl_high_q <= ctrl_high_d;
    end
  end

  // Read data stand for the one cycle after the read strobe, zero otherwise.
  always_comb begin
    rdata_d = READ_ZERO;
    if (rd_low) begin
      rdata_d = ctrl_low_q;
    end else if (rd_high) begin
      rdata_d = ctrl_high_q & CTRL_HIGH_MASK;
    end else if (rd_status) begin
      rdata_d[STATE_BIT] = state_q;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

  // Each channel passes through its own polarity bit.
  // A set polarity bit inverts the channel and a clear one passes it.
  assign g[CH1] = apply_pol(gate_in[CH1], ctrl_high_q[INV_LSB + CH1]);
  assign g[CH2] = apply_pol(gate_in[CH2], ctrl_high_q[INV_LSB + CH2]);
  assign g[CH3] = apply_pol(gate_in[CH3], ctrl_high_q[INV_LSB + CH3]);
  assign g[CH4] = apply_pol(gate_in[CH4], ctrl_high_q[INV_LSB + CH4]);

  // The mode field sits in the lowest bits of the low control word.
  assign mode = clc_mode_t'(ctrl_low_q[MODE_LSB +: MODE_W]);

  // Role signals, fixed for every mode as listed above.
  assign latch_en = g[CH1];
  assign ff_data = g[CH2];
  assign ff_data_pair = g[CH2] & g[CH3];
  assign ff_set = g[CH3];
  assign ff_rst = g[CH4];
  assign jk_j = g[CH2];
  assign jk_k = g[CH3];
  assign sr_set = g[CH1] | g[CH2];
  assign sr_rst = g[CH3] | g[CH4];

  // Edge history of channel 1, which clocks the flip-flop modes.
  always_comb begin
    clk_prev_d = g[CH1];
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
    end
  end

  assign rise = g[CH1] & ~clk_prev_q;

  // Next state of the stored modes; reset is tested first so that it wins.
  // The combinational modes leave the state as it is.
  always_comb begin
    state_d = state_q;
    case (mode)
      CLC_SR_LATCH: begin
        if (sr_rst) begin
          state_d = 1'b0;
        end else if (sr_set) begin
          state_d = 1'b1;
        end
      end
      CLC_DFF_SR: begin
        if (ff_rst) begin
          state_d = 1'b0;
        end else if (ff_set) begin
          state_d = 1'b1;
        end else if (rise) begin
          state_d = ff_data;
        end
      end
      CLC_DFF2_R: begin
        if (ff_rst) begin
          state_d = 1'b0;
        end else if (rise) begin
          state_d = ff_data_pair;
        end
      end
      CLC_JKFF_R: begin
        if (ff_rst) begin
          state_d = 1'b0;
        end else if (rise) begin
          state_d = jk_next(jk_j, jk_k, state_q);
        end
      end
      CLC_DLATCH_SR: begin
        if (ff_rst) begin
          state_d = 1'b0;
        end else if (ff_set) begin
          state_d = 1'b1;
        end else if (latch_en) begin
          state_d = ff_data;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // The output is registered, so the gate functions appear one cycle after
  // their inputs while the stored modes show the state just taken.
  always_comb begin
    comb_val = comb_eval(mode, g);
    out_d = is_comb_mode(mode) ? comb_val : state_d;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // Every data output comes straight from a flip-flop.
  assign cell_out = out_q;
endmodule : clc_core

// ### verif/clc_gate_src.sv
// Model of the on-chip sources feeding the four gate channels.
`timescale 1ns/1ps
module clc_gate_src (
  input wire logic clock_in,
  input wire logic [3:0] pat_in,
  output logic [3:0] gate_out = 4'h0
);
  always_ff @(posedge clock_in) gate_out <= pat_in;
endmodule : clc_gate_src

// ### verif/clc_core_monitor.sv
// Checker for the register port and the cell functions.
`timescale 1ns/1ps
module clc_core_monitor
  import clc_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [INV_W-1:0] gate_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic cell_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  logic [2:0] md_q, mp_q;
  logic [3:0] pol_q, g;
  logic g1p_q, rise, st, nx;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      md_q <= 3'h0;
      mp_q <= 3'h0;
      pol_q <= 4'h0;
      g1p_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == CTRL_LOW_ADDR) md_q <= wdata_in[2:0];
      if (wr_in && addr_in == CTRL_HIGH_ADDR) pol_q <= wdata_in[3:0];
      mp_q <= md_q;
      g1p_q <= g[0];
    end
  end
  // Expected next output; stored modes use the present output as state.
  always_comb begin
    g = gate_in ^ pol_q;
    rise = g[0] && !g1p_q;
    st = !wr_in && md_q == mp_q;
    case (md_q)
      3'h0: nx = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: nx = (g[0] | g[1]) ^ (g[2] | g[3]);
      3'h2: nx = &g;
      3'h3: nx = !(g[2] | g[3]) && (g[0] | g[1] | cell_out);
      3'h4: nx = !g[3] && (g[2] || (rise ? g[1] : cell_out));
      3'h5: nx = !g[3] && (rise ? g[1] & g[2] : cell_out);
      3'h6: nx = !g[3] && (rise ? g[1] & !cell_out | !g[2] & cell_out : cell_out);
      default: nx = !g[3] && (g[2] || (g[0] ? g[1] : cell_out));
    endcase
  end
  property holds(m);
    st && md_q == m |=> cell_out == $past(nx);
  endproperty
  rd_zero_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("idle rdata");
  high_rd_a: assert property ($past(rd_in) && $past(addr_in) == CTRL_HIGH_ADDR |->
    rdata_out == {12'h000, $past(pol_q)}) else $error("high readback");
  and_or_a: assert property (holds(3'h0)) else $error("and-or");
  or_xor_a: assert property (holds(3'h1)) else $error("or-xor");
  and_four_a: assert property (holds(3'h2)) else $error("and");
  sr_latch_a: assert property (holds(3'h3)) else $error("sr latch");
  dff_sr_a: assert property (holds(3'h4)) else $error("d ff set reset");
  dff_two_a: assert property (holds(3'h5)) else $error("two input d ff");
  jk_ff_a: assert property (holds(3'h6)) else $error("jk ff");
  d_latch_a: assert property (holds(3'h7)) else $error("d latch");
endmodule : clc_core_monitor

// ### verif/tb.sv
// Self-checking bench for the logic cell.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb
  import clc_pkg::*;
;
  logic clock_in = 1'b0, arst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, cell_out;
  logic [3:0] addr_in = 4'h0, pat = 4'h0, gate_in;
  logic [15:0] wdata_in = 16'h0000, rdata_out, d;
  int error_cnt = 0, checks_done = 0;
  initial forever #2 clock_in = ~clock_in;
  clc_gate_src u_clc_gate_src (.clock_in, .pat_in(pat), .gate_out(gate_in));
  clc_core u_clc_core (.clock_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .gate_in, .rdata_out, .cell_out);
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clock_in);
    arst_n_in <= 1'b1;
    rd(CTRL_HIGH_ADDR);
    `CHK("high reset", 16'h0000, d)
    wr(CTRL_HIGH_ADDR, 16'hFFFF);
    rd(CTRL_HIGH_ADDR);
    `CHK("high unused", 16'h000F, d)
    wr(CTRL_LOW_ADDR, 16'h0002);
    repeat (3) @(posedge clock_in);
    #1 `CHK("all inverted", 1'b1, cell_out)
    for (int b = 0; b < 4; b++) begin
      wr(CTRL_HIGH_ADDR, 16'h000F ^ (16'h0001 << b));
      repeat (3) @(posedge clock_in);
      #1 `CHK("one passed", 1'b0, cell_out)
    end
    wr(CTRL_HIGH_ADDR, 16'h0000);
    wr(CTRL_LOW_ADDR, 16'h0003);
    @(posedge clock_in);
    pat <= 4'h1;
    repeat (3) @(posedge clock_in);
    rd(STATUS_ADDR);
    `CHK("latch set state", 16'h0001, d)
    `CHK("latch set out", 1'b1, cell_out)
    @(posedge clock_in);
    pat <= 4'h4;
    repeat (3) @(posedge clock_in);
    rd(STATUS_ADDR);
    `CHK("latch reset state", 16'h0000, d)
    `CHK("latch reset out", 1'b0, cell_out)
    wr(CTRL_HIGH_ADDR, 16'h0006);
    for (int m = 0; m < 8; m++) begin
      wr(CTRL_LOW_ADDR, 16'hA5A0 | 16'(m));
      rd(CTRL_LOW_ADDR);
      `CHK("low control", 16'hA5A0 | 16'(m), d)
      for (int i = 0; i < 48; i++) begin
        @(posedge clock_in);
        pat <= 4'(i * 5);
      end
    end
    rd(4'hC);
    `CHK("unmapped", 16'h0000, d)
    final_report();
  end
endmodule : tb
bind clc_core clc_core_monitor u_clc_core_monitor (.clock_in, .arst_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .gate_in, .rdata_out, .cell_out);
